// ===== pkg/pepr_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef PEPR_REGS_SVH
`define PEPR_REGS_SVH

// Register indices; byte address is four times the index
`define PEPR_IDX_PAGE_SEL     5'h1F
`define PEPR_IDX_PAGED_LO     5'h10
`define PEPR_IDX_PAGED_HI     5'h1E
`define PEPR_IDX_GOOD_CRC     5'h12
`define PEPR_IDX_MODE_CTRL    5'h13
`define PEPR_IDX_PWR_SAVE     5'h14

// Page select values
`define PEPR_PAGE_MAIN        16'h0000
`define PEPR_PAGE_EXT1        16'h0001
`define PEPR_PAGE_EXT2        16'h0002
`define PEPR_PAGE_EXT3        16'h0003

// Good-CRC counter
`define PEPR_CRC_SEEN_BIT     15
`define PEPR_CRC_MAX          14'h270F
`define PEPR_CRC_RST          14'h0000

// Extended mode control fields
`define PEPR_BLINK_EN_BIT     11
`define PEPR_XOVER_LSB        2
`define PEPR_BLINK_EN_RST     1'b0
`define PEPR_XOVER_RST        2'h0

// Power save control fields
`define PEPR_CARR_DIS_BIT     15
`define PEPR_SLEEP_LSB        13
`define PEPR_WAKE_LSB         11
`define PEPR_CARR_DIS_RST     1'b1
`define PEPR_SLEEP_RST        2'h1
`define PEPR_WAKE_RST         2'h0

// Timing: core clock rate and millisecond prescaler
`define PEPR_CLK_MHZ          10
`define PEPR_TICK_TIME_US     1000
`define PEPR_TICK_CYCLES      (`PEPR_TICK_TIME_US * `PEPR_CLK_MHZ)

// Intervals in milliseconds
`define PEPR_SLEEP0_MS        12'd1000
`define PEPR_SLEEP1_MS        12'd2000
`define PEPR_SLEEP2_MS        12'd3000
`define PEPR_SLEEP3_MS        12'd4000
`define PEPR_WAKE0_MS         12'd160
`define PEPR_WAKE1_MS         12'd400
`define PEPR_WAKE2_MS         12'd800
`define PEPR_WAKE3_MS         12'd2000
`define PEPR_BLINK_MS         8'd100

`endif

// ===== pkg/pepr_pkg.sv
// Types shared by the extended page 1 register bank
package pepr_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pepr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pepr_apb_rsp_t;

    typedef enum logic [1:0] {
        PEPR_MDI_AUTO = 2'h0,
        PEPR_MDI_RSVD = 2'h1,
        PEPR_MDI_MDI  = 2'h2,
        PEPR_MDI_MDIX = 2'h3
    } pepr_mdi_t;

    typedef enum logic [1:0] {
        PEPR_PM_AWAKE = 2'h0,
        PEPR_PM_COUNT = 2'h1,
        PEPR_PM_SLEEP = 2'h3
    } pepr_pm_state_t;

endpackage

// ===== verilog/pepr_ms_timer.sv
// Millisecond interval timer driven by a prescaler tick
`timescale 1ns/1ps
module pepr_ms_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic        run_i,
    input  wire logic [11:0] limit_i,
    output logic             expired_o
);
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    wire         at_end = cnt_q >= (limit_i - 12'h001);
    wire         fire   = run_i && tick_i && at_end;

    assign cnt_d = !run_i ? 12'h000 :
                   fire   ? 12'h000 :
                   tick_i ? cnt_q + 12'h001 : cnt_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q     <= 12'h000;
            expired_o <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            expired_o <= fire;
        end
    end
endmodule

// ===== verilog/pepr_top.sv
// Extended page 1 register bank with page steering behind an APB slave
// Summary of operation
// - Writing zero restores main space for 16-30.
// - Page one steers addresses 16-30 to page one.
// - Addresses 0-15 ignore the page select.
// - Counter top bit flags packets, clears on read.
// - Low fourteen bits count good packets modulo 10000.
// - Count wraps from 9999 to zero, no saturation.
// - Reading clears counter; counter resets to zero.
// - Mode bit 11 enables blink after hold release.
// - Crossover field selects auto, MDI or MDI-X.
// - Power bit 15 disables carrier extension.
// - Sleep field selects one to four seconds.
// - Wake field selects 160/400/800 ms or 2 s.
// - Page select also accepts pages two and three.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pepr_regs.svh"
module pepr_top #(
    parameter int unsigned TICK_CYCLES = `PEPR_TICK_CYCLES
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RST_I,
    input  wire pepr_pkg::pepr_apb_req_t APB_REQ_I,
    output pepr_pkg::pepr_apb_rsp_t     APB_RSP_O,
    input  wire logic                   GOOD_PKT_I,
    input  wire logic                   LOW_POWER_HOLD_I,
    input  wire logic                   LINK_ENERGY_I,
    output logic                        LED_BLINK_O,
    output pepr_pkg::pepr_mdi_t         MDI_MODE_O,
    output logic                        CARRIER_EXT_DIS_O,
    output logic                        SLEEP_O,
    output logic                        WAKE_O
);
    import pepr_pkg::*;

    // Bus response and page state
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic [15:0]    page_q;
    logic [15:0]    main_q [0:30];
    logic [15:0]    ext_q  [0:1][0:14];

    // Page 1 fields
    logic [13:0]    cnt_q;
    logic [13:0]    cnt_d;
    logic           seen_q;
    logic           blink_en_q;
    logic [1:0]     xover_q;
    logic           carr_dis_q;
    logic [1:0]     sleep_sel_q;
    logic [1:0]     wake_sel_q;

    // Pin synchronisers, blink and power state
    logic [1:0]     sync1_q;
    logic [1:0]     sync2_q;
    logic           hold_prev_q;
    logic [7:0]     blink_cnt_q;
    logic [7:0]     blink_cnt_d;
    logic [15:0]    presc_q;
    logic           tick_q;
    pepr_pm_state_t pm_q;
    pepr_pm_state_t pm_d;
    pepr_mdi_t      mdi_q;
    logic           sleep_exp;
    logic           wake_exp;

    // Address decode
    wire [4:0]  idx      = APB_REQ_I.paddr[6:2];
    wire [15:0] wdata    = APB_REQ_I.pwdata[15:0];
    wire        addr_ok  = !APB_REQ_I.paddr[7] &&
                           (APB_REQ_I.paddr[1:0] == 2'h0);
    wire        acc_go   = APB_REQ_I.psel && APB_REQ_I.penable && !pready_q;
    wire        wr_go    = acc_go && APB_REQ_I.pwrite && addr_ok;
    wire        rd_go    = acc_go && !APB_REQ_I.pwrite && addr_ok;
    wire        is_pgreg = idx == `PEPR_IDX_PAGE_SEL;
    wire        is_paged = (idx >= `PEPR_IDX_PAGED_LO) &&
                           (idx <= `PEPR_IDX_PAGED_HI);
    wire        sel_main = (!is_paged && !is_pgreg) ||
                           (is_paged && page_q == `PEPR_PAGE_MAIN);
    wire        sel_p1   = is_paged && page_q == `PEPR_PAGE_EXT1;
    wire        sel_px   = is_paged && (page_q == `PEPR_PAGE_EXT2 ||
                                        page_q == `PEPR_PAGE_EXT3);
    wire        ext_pg   = page_q[0];
    wire        p1_mode  = sel_p1 && idx == `PEPR_IDX_MODE_CTRL;
    wire        p1_pwr   = sel_p1 && idx == `PEPR_IDX_PWR_SAVE;
    wire        crc_rd   = rd_go && sel_p1 && idx == `PEPR_IDX_GOOD_CRC;

    // Read data selection
    wire [15:0] crc_word  = {seen_q, 1'b0, cnt_q};
    wire [15:0] mode_word = {4'h0, blink_en_q, 7'h00, xover_q, 2'h0};
    wire [15:0] pwr_word  = {carr_dis_q, sleep_sel_q, wake_sel_q, 11'h000};
    wire [15:0] p1_rdata  = idx == `PEPR_IDX_GOOD_CRC ? crc_word :
                            p1_mode ? mode_word :
                            p1_pwr  ? pwr_word : 16'h0000;
    wire [15:0] rdata16   = !addr_ok ? 16'h0000 :
                            is_pgreg ? page_q :
                            sel_p1   ? p1_rdata :
                            sel_px   ? ext_q[ext_pg][idx[3:0]] :
                            sel_main ? main_q[idx] : 16'h0000;

    assign APB_RSP_O = '{prdata: prdata_q, pready: pready_q,
                         pslverr: pslverr_q};

    // Single wait state: data and ready are registered together
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc_go;
            pslverr_q <= acc_go && !addr_ok;
            if (acc_go) begin
                prdata_q <= {16'h0000, rdata16};
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            page_q <= `PEPR_PAGE_MAIN;
        end else if (wr_go && is_pgreg) begin
            page_q <= wdata;
        end
    end

    // Main space storage, one word per address 0 to 30
    genvar gi;
    genvar gp;
    generate
        for (gi = 0; gi < 31; gi++) begin : g_main
            always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    main_q[gi] <= 16'h0000;
                end else if (wr_go && sel_main && idx == 5'(gi)) begin
                    main_q[gi] <= wdata;
                end
            end
        end
        for (gp = 0; gp < 2; gp++) begin : g_pg
            for (gi = 0; gi < 15; gi++) begin : g_ext
                always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
                    if (RST_I) begin
                        ext_q[gp][gi] <= 16'h0000;
                    end else if (wr_go && sel_px && ext_pg == 1'(gp) &&
                                 idx[3:0] == 4'(gi)) begin
                        ext_q[gp][gi] <= wdata;
                    end
                end
            end
        end
    endgenerate

    // Good-CRC counter; a packet in the clearing cycle still counts
    wire [13:0] cnt_inc = (cnt_q == `PEPR_CRC_MAX) ? 14'h0000 :
                          cnt_q + 14'h0001;
    assign cnt_d = crc_rd ? (GOOD_PKT_I ? 14'h0001 : 14'h0000) :
                   GOOD_PKT_I ? cnt_inc : cnt_q;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_q  <= `PEPR_CRC_RST;
            seen_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            seen_q <= GOOD_PKT_I || (seen_q && !crc_rd);
        end
    end

    // Page 1 control fields
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            blink_en_q  <= `PEPR_BLINK_EN_RST;
            xover_q     <= `PEPR_XOVER_RST;
            carr_dis_q  <= `PEPR_CARR_DIS_RST;
            sleep_sel_q <= `PEPR_SLEEP_RST;
            wake_sel_q  <= `PEPR_WAKE_RST;
        end else if (wr_go && p1_mode) begin
            blink_en_q  <= wdata[`PEPR_BLINK_EN_BIT];
            xover_q     <= wdata[`PEPR_XOVER_LSB +: 2];
        end else if (wr_go && p1_pwr) begin
            carr_dis_q  <= wdata[`PEPR_CARR_DIS_BIT];
            sleep_sel_q <= wdata[`PEPR_SLEEP_LSB +: 2];
            wake_sel_q  <= wdata[`PEPR_WAKE_LSB +: 2];
        end
    end

    // Reserved crossover code behaves as automatic
    wire pepr_mdi_t mdi_sel = (xover_q == 2'h1) ? PEPR_MDI_AUTO :
                              pepr_mdi_t'(xover_q);
    assign CARRIER_EXT_DIS_O = carr_dis_q;
    assign MDI_MODE_O        = mdi_q;

    // Two-stage synchronisers: bit 0 hold input, bit 1 link energy
    wire hold_s    = sync2_q[0];
    wire energy_s  = sync2_q[1];
    wire released  = hold_prev_q && !hold_s;
    assign blink_cnt_d = (released && blink_en_q) ? `PEPR_BLINK_MS :
                         (tick_q && blink_cnt_q != 8'h00) ?
                         blink_cnt_q - 8'h01 : blink_cnt_q;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1_q     <= 2'h0;
            sync2_q     <= 2'h0;
            hold_prev_q <= 1'b0;
            blink_cnt_q <= 8'h00;
            LED_BLINK_O <= 1'b0;
            mdi_q       <= PEPR_MDI_AUTO;
        end else begin
            sync1_q     <= {LINK_ENERGY_I, LOW_POWER_HOLD_I};
            sync2_q     <= sync1_q;
            hold_prev_q <= hold_s;
            blink_cnt_q <= blink_cnt_d;
            LED_BLINK_O <= blink_cnt_d != 8'h00;
            mdi_q       <= mdi_sel;
        end
    end

    // Millisecond prescaler from the core clock
    wire presc_end = presc_q == 16'(TICK_CYCLES - 1);
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            presc_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else begin
            presc_q <= presc_end ? 16'h0000 : presc_q + 16'h0001;
            tick_q  <= presc_end;
        end
    end

    // Interval selection
    wire [11:0] sleep_ms = sleep_sel_q == 2'h0 ? `PEPR_SLEEP0_MS :
                           sleep_sel_q == 2'h1 ? `PEPR_SLEEP1_MS :
                           sleep_sel_q == 2'h2 ? `PEPR_SLEEP2_MS :
                           `PEPR_SLEEP3_MS;
    wire [11:0] wake_ms  = wake_sel_q == 2'h0 ? `PEPR_WAKE0_MS :
                           wake_sel_q == 2'h1 ? `PEPR_WAKE1_MS :
                           wake_sel_q == 2'h2 ? `PEPR_WAKE2_MS :
                           `PEPR_WAKE3_MS;

    pepr_ms_timer u_sleep_tmr (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RST_I),
        .tick_i    (tick_q),
        .run_i     (pm_q == PEPR_PM_COUNT && !energy_s),
        .limit_i   (sleep_ms),
        .expired_o (sleep_exp)
    );

    pepr_ms_timer u_wake_tmr (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RST_I),
        .tick_i    (tick_q),
        .run_i     (pm_q == PEPR_PM_SLEEP && !energy_s),
        .limit_i   (wake_ms),
        .expired_o (wake_exp)
    );

    // Power state: no energy starts the sleep wait, energy wakes at once
    always_comb begin
        pm_d = pm_q;
        case (pm_q)
            PEPR_PM_AWAKE: begin
                if (!energy_s) begin
                    pm_d = PEPR_PM_COUNT;
                end
            end
            PEPR_PM_COUNT: begin
                if (energy_s) begin
                    pm_d = PEPR_PM_AWAKE;
                end else if (sleep_exp) begin
                    pm_d = PEPR_PM_SLEEP;
                end
            end
            PEPR_PM_SLEEP: begin
                if (energy_s) begin
                    pm_d = PEPR_PM_AWAKE;
                end
            end
            default: begin
                pm_d = PEPR_PM_AWAKE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pm_q    <= PEPR_PM_AWAKE;
            SLEEP_O <= 1'b0;
            WAKE_O  <= 1'b0;
        end else begin
            pm_q    <= pm_d;
            SLEEP_O <= pm_d == PEPR_PM_SLEEP;
            WAKE_O  <= wake_exp && pm_d == PEPR_PM_SLEEP;
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_crc_read;
        crc_rd && !GOOD_PKT_I;
    endsequence
    sequence s_pkt_only;
        GOOD_PKT_I && !crc_rd;
    endsequence

    a_page_zero_main: assert property (wr_go && is_pgreg &&
        wdata == 16'h0000 |=> page_q == 16'h0000 && !sel_p1)
        else $error("page zero write did not restore main space");
    a_page_ext_accept: assert property (wr_go && is_pgreg &&
        wdata == 16'h0003 |=> page_q == 16'h0003)
        else $error("page three not accepted");
    a_paged_p1_read: assert property (rd_go && p1_mode |=>
        pready_q && prdata_q[11] == $past(blink_en_q))
        else $error("page one read not steered");
    a_low_unpaged: assert property (wr_go && idx < 5'h10 |=>
        main_q[$past(idx)] == $past(wdata))
        else $error("low address write missed main register");
    a_crc_flag_clr: assert property (s_crc_read |=>
        !seen_q ##1 (seen_q == $past(GOOD_PKT_I)))
        else $error("packet flag not cleared by read");
    a_crc_count_up: assert property (s_pkt_only and
        (cnt_q < 14'h270F) |=> cnt_q == $past(cnt_q) + 14'h0001 && seen_q)
        else $error("good packet not counted");
    a_crc_wrap_zero: assert property (s_pkt_only and
        (cnt_q == 14'h270F) |=> cnt_q == 14'h0000)
        else $error("counter did not wrap after 9999");
    a_crc_read_clr: assert property (crc_rd |=>
        cnt_q == ($past(GOOD_PKT_I) ? 14'h0001 : 14'h0000))
        else $error("counter not cleared by read");
    a_blink_release: assert property (released && blink_en_q
        |=> LED_BLINK_O [*2])
        else $error("no blink after hold release");
    a_blink_suppress: assert property (released && !blink_en_q &&
        blink_cnt_q == 8'h00 |=> !LED_BLINK_O)
        else $error("blink not suppressed");
    a_mdi_select: assert property (##1 MDI_MODE_O ==
        (($past(xover_q) == 2'h1) ? PEPR_MDI_AUTO : $past(xover_q)))
        else $error("crossover mode mismatch");
    a_wake_pulse: assert property (WAKE_O |-> SLEEP_O ##1 !WAKE_O)
        else $error("wake pulse malformed");
endmodule

// ===== dv/tb.sv
// Self-checking bench for the extended page 1 register bank
`timescale 1ns/1ps
`include "pepr_regs.svh"
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    import pepr_pkg::*;
    localparam int TICK = 4;
    logic          clk;
    logic          rst;
    pepr_apb_req_t req;
    pepr_apb_rsp_t rsp;
    logic          good_pkt;
    logic          hold;
    logic          energy;
    logic          led_blink;
    pepr_mdi_t     mdi_mode;
    logic          carr_dis;
    logic          sleep;
    logic          wake;
    int            fail_count = 0;
    int            checked = 0;

    pepr_top #(.TICK_CYCLES(TICK)) i_dut (
        .SYS_CLK_I        (clk),
        .RST_I            (rst),
        .APB_REQ_I        (req),
        .APB_RSP_O        (rsp),
        .GOOD_PKT_I       (good_pkt),
        .LOW_POWER_HOLD_I (hold),
        .LINK_ENERGY_I    (energy),
        .LED_BLINK_O      (led_blink),
        .MDI_MODE_O       (mdi_mode),
        .CARRIER_EXT_DIS_O(carr_dis),
        .SLEEP_O          (sleep),
        .WAKE_O           (wake)
    );

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input string nm);
        fail_count++;
        $display("BAD %s exp 1 got 0", nm);
        test_done();
    endtask

    function automatic logic [7:0] ba(input logic [4:0] i);
        return {1'b0, i, 2'b00};
    endfunction

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [15:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: {16'h0000, wd}};
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n == 20) hang("pready");
    endtask

    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ba(i), d, r, e);
    endtask

    task automatic rdc(input string nm, input logic [4:0] i,
                       input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, ba(i), 16'h0000, r, e);
        `CHK(nm, x, r)
    endtask

    // Waits for sleep (0), wake (1) or blink (2) to be seen high
    task automatic wait_hi(input int s, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if ((s == 0 ? sleep : s == 1 ? wake : led_blink) === 1'b1) break;
        end
        if (n == lim) hang("wait_hi");
    endtask

    task automatic t_reset();
        rdc("page_rst", `PEPR_IDX_PAGE_SEL, 32'h0);
        `CHK("carr_pin", 1'b1, carr_dis)
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT1);
        rdc("cnt_rst", `PEPR_IDX_GOOD_CRC, 32'h0);
        rdc("mode_rst", `PEPR_IDX_MODE_CTRL, 32'h0);
        rdc("pwr_rst", `PEPR_IDX_PWR_SAVE, 32'hA000);
    endtask

    task automatic t_paging();
        logic [31:0] r;
        logic        e;
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_MAIN);
        wr(`PEPR_IDX_MODE_CTRL, 16'h1234);
        wr(5'h05, 16'hBEEF);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT1);
        wr(`PEPR_IDX_MODE_CTRL, 16'h0008);
        rdc("p1_mode", `PEPR_IDX_MODE_CTRL, 32'h0008);
        rdc("low_p1", 5'h05, 32'hBEEF);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT2);
        wr(`PEPR_IDX_MODE_CTRL, 16'h5555);
        rdc("low_p2", 5'h05, 32'hBEEF);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT3);
        rdc("p3_mode", `PEPR_IDX_MODE_CTRL, 32'h0);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT2);
        rdc("p2_mode", `PEPR_IDX_MODE_CTRL, 32'h5555);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_MAIN);
        rdc("main_mode", `PEPR_IDX_MODE_CTRL, 32'h1234);
        wr(`PEPR_IDX_PAGE_SEL, `PEPR_PAGE_EXT1);
        rdc("p1_keep", `PEPR_IDX_MODE_CTRL, 32'h0008);
        apb(1'b0, 8'h49, 16'h0000, r, e);
        `CHK("slverr", 1'b1, e)
    endtask

    task automatic t_mode();
        int          n;
        logic        seen;
        logic        ok;
        pepr_mdi_t   xm;
        logic [31:0] xv;
        for (int k = 0; k < 4; k++) begin
            wr(`PEPR_IDX_MODE_CTRL, {12'h000, k[1:0], 2'b00});
            repeat (2) @(posedge clk);
            xm = (k == 1) ? PEPR_MDI_AUTO : pepr_mdi_t'(k[1:0]);
            `CHK("mdi_pin", xm, mdi_mode)
            xv = {28'h0, k[1:0], 2'b00};
            rdc("mdi_reg", `PEPR_IDX_MODE_CTRL, xv);
        end
        wr(`PEPR_IDX_MODE_CTRL, 16'hFFFF);
        rdc("mode_ro", `PEPR_IDX_MODE_CTRL, 32'h080C);
        hold <= 1'b1;
        repeat (10) @(posedge clk);
        hold <= 1'b0;
        wait_hi(2, 20, n);
        for (n = 0; n < 600 && led_blink === 1'b1; n++) @(posedge clk);
        ok = n >= 100 * TICK - 8 && n <= 100 * TICK + 8;
        `CHK("blink_len", 1'b1, ok)
        wr(`PEPR_IDX_MODE_CTRL, 16'h0000);
        hold <= 1'b1;
        repeat (10) @(posedge clk);
        hold <= 1'b0;
        seen = 1'b0;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            seen = seen | led_blink;
        end
        `CHK("no_blink", 1'b0, seen)
    endtask

    task automatic pulses(input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            good_pkt <= 1'b1;
            @(posedge clk);
            good_pkt <= 1'b0;
        end
    endtask

    task automatic t_count();
        rdc("cnt_clr", `PEPR_IDX_GOOD_CRC, 32'h0);
        pulses(5);
        rdc("cnt_5", `PEPR_IDX_GOOD_CRC, 32'h8005);
        rdc("cnt_rc", `PEPR_IDX_GOOD_CRC, 32'h0);
        pulses(10001);
        rdc("cnt_wrap", `PEPR_IDX_GOOD_CRC, 32'h8001);
        pulses(9);
        rdc("cnt_9", `PEPR_IDX_GOOD_CRC, 32'h8009);
        // Packet lands on the clearing edge: it must survive the clear
        fork
            rdc("cnt_race", `PEPR_IDX_GOOD_CRC, 32'h0);
            begin
                repeat (2) @(posedge clk);
                good_pkt <= 1'b1;
                @(posedge clk);
                good_pkt <= 1'b0;
            end
        join
        rdc("cnt_set", `PEPR_IDX_GOOD_CRC, 32'h8001);
    endtask

    task automatic t_power();
        int   n;
        int   t;
        logic ok;
        int   wk[4] = '{160, 400, 800, 2000};
        for (int k = 0; k < 4; k++) begin
            wr(`PEPR_IDX_PWR_SAVE, {1'b1, k[1:0], k[1:0], 11'h000});
            energy <= 1'b0;
            t = (k + 1) * 1000 * TICK;
            wait_hi(0, 20000, n);
            ok = n >= t - TICK - 6 && n <= t + TICK + 6;
            `CHK("sleep_time", 1'b1, ok)
            t = wk[k] * TICK;
            wait_hi(1, 9000, n);
            ok = n >= t - TICK - 6 && n <= t + TICK + 6;
            `CHK("wake_time", 1'b1, ok)
            energy <= 1'b1;
            repeat (5) @(posedge clk);
            `CHK("awake", 1'b0, sleep)
        end
        wr(`PEPR_IDX_PWR_SAVE, 16'h7FFF);
        repeat (2) @(posedge clk);
        `CHK("carr_off", 1'b0, carr_dis)
        rdc("pwr_ro", `PEPR_IDX_PWR_SAVE, 32'h7800);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        req = '0;
        good_pkt = 1'b0;
        hold = 1'b0;
        energy = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_paging();
        t_mode();
        t_count();
        t_power();
        test_done();
    end
endmodule
